// ===== hdl/ecp_pkg.sv
/*
 * Shared constants, modes, states and carriers for the parallel port
 * handshake engine. Assumes a single 50 MHz clock.
 */
`default_nettype none
package ecp_pkg;
   localparam int CLK_NS      = 20;
   localparam int T_SETUP_NS  = 600;
   localparam int T_STB_NS    = 600;
   localparam int T_HOLD_NS   = 450;
   localparam int T_GAP_NS    = 680;
   localparam int T_ECP_NS    = 80;
   localparam int T_FILT_NS   = 75;
   // least times round up to whole cycles
   localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STB_CYC     = (T_STB_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC     = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ECP_CYC     = (T_ECP_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT_CYC    = (T_FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam int CW          = 6;
   localparam int FW          = 3;
   localparam int BUF_DEPTH   = 2;
   localparam logic RST_BUSY  = 1'b0;
   localparam logic RST_ACK_N = 1'b1;
   localparam logic RST_FAULT_N = 1'b1;

   typedef enum logic [1:0] {
      MODE_COMPAT = 2'h0,
      MODE_FIFO   = 2'h1,
      MODE_ECP    = 2'h2
   } ecp_mode_t;

   typedef enum logic [3:0] {
      ST_FIDLE  = 4'h0,
      ST_SETUP  = 4'h1,
      ST_STB    = 4'h2,
      ST_HOLD   = 4'h3,
      ST_EF_WHI = 4'h4,
      ST_EF_DLY = 4'h5,
      ST_EF_WLO = 4'h6,
      ST_EF_GAP = 4'h7,
      ST_RIDLE  = 4'h8,
      ST_R_DLY  = 4'h9,
      ST_R_WHI  = 4'ha,
      ST_R_GAP  = 4'hb
   } ecp_state_t;

   typedef struct packed {
      logic       cmd;
      logic [7:0] data;
   } ecp_word_t;

   typedef struct packed {
      logic [7:0] data;
      logic       strobe_n;
      logic       alf_n;
   } ecp_pins_t;

   typedef struct packed {
      logic [7:0] data_oe_n;
      logic       strobe_oe_n;
      logic       alf_oe_n;
   } ecp_oe_t;
endpackage
`default_nettype wire

// ===== hdl/ecp_handshake.sv
/*
 * Handshake engine of a multi-mode parallel port: FIFO/compatible
 * forward transfers paced by BUSY, ECP forward and reverse phases,
 * settling filters on BUSY and nACK, and driver mode switching.
 * Assumes the port FIFO side is valid/ready and all inputs are
 * synchronous to clk; the cable wire level is resolved outside.
 */
// Contract
// [R1] fifo mode paced by busy, ack ignored
// [R2] data 600 ns before strobe, strobe 600 ns
// [R3] 680 ns from busy low to strobe
// [R4] hold data past busy and 450 ns
// [R5] peripheral raises busy within 500 ns
// [R6] forward idle keeps host clock high
// [R7] forward ecp byte interlocked with busy
// [R8] synchronise and accept peripheral request
// [R9] ecp data and alf valid with strobe
// [R10] ecp data changes 80-180 ns after busy
// [R11] next strobe 80-200 ns after busy low
// [R12] strobe released 80-180 ns after busy high
// [R13] upper limits only while data pending
// [R14] busy filtered over 75-130 ns window
// [R15] reverse idle keeps host ack low
// [R16] reverse ecp byte interlocked with ack
// [R17] alf released 80-200 ns after ack low
// [R18] alf reasserted 80-200 ns after ack high
// [R19] stall by holding alf low when full
// [R20] ack filtered over 75-130 ns window
// [R21] push-pull in ecp, open-collector otherwise, glitch-free
// [R22] reset returns to forward idle
`timescale 1ns/10ps
`default_nettype none
module ecp_handshake
   import ecp_pkg::*;
(
   // clock and reset
   input  wire logic      clk,
   input  wire logic      reset,
   // configuration
   input  wire ecp_mode_t mode,
   input  wire logic      reverse,
   // forward words from the port fifo
   input  wire ecp_word_t tx_word,
   input  wire logic      tx_valid,
   output logic           tx_ready,
   // reverse bytes to the port fifo
   output logic [7:0]     rx_data,
   output logic           rx_valid,
   input  wire logic      rx_ready,
   input  wire logic      tc,
   // cable inputs
   input  wire logic      busy,
   input  wire logic      ack_n,
   input  wire logic      fault_n,
   input  wire logic [7:0] pd_in,
   // cable outputs
   output ecp_pins_t      pins,
   output ecp_oe_t        pins_oe,
   output logic           periph_req
);

   function automatic ecp_pins_t ecp_load(input ecp_pins_t p, input ecp_word_t w);
      ecp_pins_t r;
      r          = p;
      r.data     = w.data;
      r.alf_n    = ~w.cmd;
      r.strobe_n = 1'b0;
      return r;
   endfunction

   // two-entry forward buffer
   ecp_word_t          buf_mem [BUF_DEPTH];
   logic               wr_ptr;
   logic               rd_ptr;
   logic [1:0]         buf_cnt;
   logic               next_wr_ptr;
   logic               next_rd_ptr;
   logic [1:0]         next_buf_cnt;
   logic               pop;
   logic               buf_valid;
   ecp_word_t          head;

   assign tx_ready  = (buf_cnt != 2'h2);
   assign buf_valid = (buf_cnt != 2'h0);
   assign head      = buf_mem[rd_ptr];

   always_comb begin
      next_wr_ptr  = wr_ptr;
      next_rd_ptr  = rd_ptr;
      next_buf_cnt = buf_cnt;
      if (tx_valid && tx_ready) begin
         next_wr_ptr = ~wr_ptr;
      end
      if (pop) begin
         next_rd_ptr = ~rd_ptr;
      end
      case ({tx_valid && tx_ready, pop})
         2'b10:   next_buf_cnt = buf_cnt + 2'h1;
         2'b01:   next_buf_cnt = buf_cnt - 2'h1;
         default: next_buf_cnt = buf_cnt;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         buf_cnt <= 2'h0;
      end else begin
         wr_ptr  <= next_wr_ptr;
         rd_ptr  <= next_rd_ptr;
         buf_cnt <= next_buf_cnt;
      end
      if (tx_valid && tx_ready) begin
         buf_mem[wr_ptr] <= tx_word;
      end
   end

   // settling filters: index 0 busy, index 1 ack_n
   logic [1:0]         f_last;
   logic [1:0]         f_lvl;
   logic [FW-1:0]      f_cnt [2];
   logic [1:0]         next_f_last;
   logic [1:0]         next_f_lvl;
   logic [FW-1:0]      next_f_cnt [2];
   logic [1:0]         raw;
   logic               busy_f;
   logic               ack_f;
   logic               fault_s1;
   logic               fault_s2;

   assign raw    = {ack_n, busy};
   assign busy_f = f_lvl[0];
   assign ack_f  = f_lvl[1];

   // a level is taken only after FILT_CYC quiet samples: ~100 ns
   always_comb begin
      next_f_last = raw;
      next_f_lvl  = f_lvl;
      for (int i = 0; i < 2; i++) begin
         if (raw[i] != f_last[i]) begin
            next_f_cnt[i] = '0;
         end else if (f_cnt[i] != FW'(FILT_CYC)) begin
            next_f_cnt[i] = f_cnt[i] + FW'(1);
         end else begin
            next_f_cnt[i] = f_cnt[i];
         end
         if (f_cnt[i] == FW'(FILT_CYC)) begin
            next_f_lvl[i] = f_last[i]; // [R14] [R20]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         f_last   <= {RST_ACK_N, RST_BUSY};
         f_lvl    <= {RST_ACK_N, RST_BUSY};
         f_cnt[0] <= '0;
         f_cnt[1] <= '0;
         fault_s1 <= RST_FAULT_N;
         fault_s2 <= RST_FAULT_N;
      end else begin
         f_last   <= next_f_last;
         f_lvl    <= next_f_lvl;
         f_cnt[0] <= next_f_cnt[0];
         f_cnt[1] <= next_f_cnt[1];
         fault_s1 <= fault_n;
         fault_s2 <= fault_s1; // [R8]
      end
   end

   // transfer machine
   ecp_state_t         state;
   ecp_state_t         next_state;
   logic [CW-1:0]      cnt;
   logic [CW-1:0]      next_cnt;
   logic [CW-1:0]      gap;
   logic [CW-1:0]      next_gap;
   logic               drive_pp;
   logic               next_pp;
   ecp_pins_t          next_pins;
   ecp_oe_t            next_oe;
   logic [7:0]         next_rx_data;
   logic               next_rx_valid;
   logic               next_req;
   logic               rev;
   logic               pending;

   // pending gates the upper pacing limits; without it we just idle
   assign pending = buf_valid && !reverse && (mode == MODE_ECP); // [R13]

   always_comb begin
      next_state    = state;
      next_cnt      = (cnt != '0) ? cnt - CW'(1) : cnt;
      next_gap      = busy_f ? CW'(GAP_CYC) : ((gap != '0) ? gap - CW'(1) : gap); // [R3]
      next_pins     = pins;
      next_pp       = drive_pp;
      next_rx_data  = rx_data;
      next_rx_valid = rx_valid && !rx_ready;
      next_req      = ~fault_s2;
      pop           = 1'b0;
      case (state)
         ST_FIDLE: begin
            next_pins.strobe_n = 1'b1; // [R6]
            // drivers only swap here; both strobes are high except when ECP is entered with reverse set or a word buffered, or the last ECP word left alf_n low
            next_pp = (mode == MODE_ECP); // [R21]
            if (mode != MODE_ECP) begin
               next_pins.alf_n = 1'b1;
               if (buf_valid && !busy_f) begin // [R1]
                  next_pins.data = head.data;
                  pop            = 1'b1;
                  next_cnt       = CW'(SETUP_CYC);
                  next_state     = ST_SETUP;
               end
            end else if (reverse) begin
               next_pins.alf_n = 1'b0; // [R15]
               next_state      = ST_RIDLE;
            end else if (buf_valid && !busy_f) begin
               next_pins  = ecp_load(pins, head); // [R7] [R9]
               pop        = 1'b1;
               next_state = ST_EF_WHI;
            end
         end
         ST_SETUP: begin
            if (cnt == '0 && gap == '0) begin // [R2] [R3]
               next_pins.strobe_n = 1'b0;
               next_cnt           = CW'(STB_CYC);
               next_state         = ST_STB;
            end
         end
         ST_STB: begin
            if (cnt == '0) begin // [R2]
               next_pins.strobe_n = 1'b1;
               next_cnt           = CW'(HOLD_CYC);
               next_state         = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // data stays on the pins until the next load
            if (cnt == '0 && !busy_f) begin // [R4] [R5]
               next_state = ST_FIDLE;
            end
         end
         ST_EF_WHI: begin
            if (busy_f) begin // [R7]
               next_cnt   = CW'(ECP_CYC);
               next_state = ST_EF_DLY;
            end
         end
         ST_EF_DLY: begin
            if (cnt == '0) begin
               next_pins.strobe_n = 1'b1; // [R12]
               next_state         = ST_EF_WLO;
            end
         end
         ST_EF_WLO: begin
            if (!busy_f) begin
               next_cnt   = CW'(ECP_CYC);
               next_state = ST_EF_GAP;
            end
         end
         ST_EF_GAP: begin
            if (cnt == '0) begin
               if (pending) begin
                  next_pins  = ecp_load(pins, head); // [R10] [R11]
                  pop        = 1'b1;
                  next_state = ST_EF_WHI;
               end else begin
                  next_state = ST_FIDLE;
               end
            end
         end
         ST_RIDLE: begin
            next_pins.alf_n = 1'b0;
            if (!reverse && ack_f) begin
               next_pins.alf_n = 1'b1;
               next_state      = ST_FIDLE;
            end else if (!ack_f && !rx_valid && !tc) begin // [R19]
               next_cnt   = CW'(ECP_CYC);
               next_state = ST_R_DLY;
            end
         end
         ST_R_DLY: begin
            if (cnt == '0) begin
               next_pins.alf_n = 1'b1; // [R16] [R17]
               next_rx_data    = pd_in;
               next_state      = ST_R_WHI;
            end
         end
         ST_R_WHI: begin
            if (ack_f) begin
               next_cnt   = CW'(ECP_CYC);
               next_state = ST_R_GAP;
            end
         end
         ST_R_GAP: begin
            if (cnt == '0) begin
               next_pins.alf_n = 1'b0; // [R16] [R18]
               next_rx_valid   = 1'b1;
               next_state      = ST_RIDLE;
            end
         end
         default: begin
            next_pins.strobe_n = 1'b1;
            next_state         = ST_FIDLE;
         end
      endcase
      rev = (next_state == ST_RIDLE) || (next_state == ST_R_DLY) ||
            (next_state == ST_R_WHI) || (next_state == ST_R_GAP);
      // open-collector: enable only while the pin is pulled low
      next_oe.data_oe_n   = rev ? 8'hff : (next_pp ? 8'h00 : next_pins.data); // [R21]
      next_oe.strobe_oe_n = next_pp ? 1'b0 : next_pins.strobe_n;
      next_oe.alf_oe_n    = next_pp ? 1'b0 : next_pins.alf_n;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state      <= ST_FIDLE; // [R22]
         cnt        <= '0;
         gap        <= '0;
         drive_pp   <= 1'b0;
         pins       <= '{data: 8'hff, strobe_n: 1'b1, alf_n: 1'b1};
         pins_oe    <= '{data_oe_n: 8'hff, strobe_oe_n: 1'b1, alf_oe_n: 1'b1};
         rx_data    <= 8'h00;
         rx_valid   <= 1'b0;
         periph_req <= 1'b0;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         gap        <= next_gap;
         drive_pp   <= next_pp;
         pins       <= next_pins;
         pins_oe    <= next_oe;
         rx_data    <= next_rx_data;
         rx_valid   <= next_rx_valid;
         periph_req <= next_req;
      end
   end
endmodule
`default_nettype wire

// ===== tb/ecp_handshake_monitor.sv
/* assertions on the handshake engine ports.
   assumes one clock and the sync reset of ecp_handshake */
`timescale 1ns/10ps
`default_nettype none
module ecp_handshake_monitor
   import ecp_pkg::*;
(
   // clock and reset
   input wire logic      clk,
   input wire logic      reset,
   // control
   input wire ecp_mode_t mode,
   input wire logic      reverse,
   input wire logic      tx_ready,
   input wire logic      rx_valid,
   input wire logic      tc,
   // cable
   input wire logic      busy,
   input wire logic      ack_n,
   input wire logic      fault_n,
   input wire ecp_pins_t pins,
   input wire ecp_oe_t   pins_oe,
   input wire logic      periph_req
);
   logic fifo_m, ecp_f, ecp_r;
   assign fifo_m = mode != MODE_ECP;
   assign ecp_f = mode == MODE_ECP && !reverse;
   assign ecp_r = mode == MODE_ECP && reverse;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_reset_idle:
   assert property (disable iff (1'b0) reset |=> pins.strobe_n && pins.alf_n
      && &pins_oe && !rx_valid && !periph_req) else $error("bad reset state");
   chk_stb_width:
   assert property (fifo_m && $rose(pins.strobe_n) |-> !$past(pins.strobe_n, 30))
      else $error("strobe too short");
   chk_busy_gap:
   assert property (fifo_m && $fell(pins.strobe_n) |-> !busy && !$past(busy, 34))
      else $error("strobe too soon");
   chk_data_hold:
   assert property (fifo_m && $changed(pins.data) |-> !busy && $past(pins.strobe_n, 23))
      else $error("data hold short");
   chk_req_sync:
   assert property (!fault_n [*5] |-> periph_req) else $error("request lost");
   chk_stb_release:
   assert property (ecp_f && !pins.strobe_n && $rose(busy) |->
      !pins.strobe_n [*4] ##[1:11] pins.strobe_n) else $error("release timing");
   // a full buffer is the only pending state visible from the ports
   chk_next_byte:
   assert property (ecp_f && pins.strobe_n && !tx_ready && $fell(busy) |->
      (pins.strobe_n && $stable(pins.data)) [*4] ##[1:11] !pins.strobe_n)
      else $error("next byte timing");
   chk_rev_order:
   assert property (ecp_r && $changed(pins.alf_n) |-> ack_n == !pins.alf_n)
      else $error("reverse order");
   chk_rev_release:
   assert property (ecp_r && !pins.alf_n && !rx_valid && !tc && $fell(ack_n) |->
      !pins.alf_n [*4] ##[1:11] pins.alf_n) else $error("alf release timing");
   chk_rev_return:
   assert property (ecp_r && pins.alf_n && $rose(ack_n) |->
      pins.alf_n [*4] ##[1:11] !pins.alf_n) else $error("alf return timing");
   chk_rev_stall:
   assert property ((ecp_r && (tc || rx_valid) && !pins.alf_n) [*6] |=> !pins.alf_n)
      else $error("stall broken");
   cover property (ecp_f && $rose(pins.strobe_n));
   cover property (ecp_r && $rose(rx_valid));
   cover property (fifo_m && $fell(pins.strobe_n));
endmodule
bind ecp_handshake ecp_handshake_monitor chk (.clk, .reset, .mode, .reverse,
   .tx_ready, .rx_valid, .tc, .busy, .ack_n, .fault_n, .pins, .pins_oe, .periph_req);
`default_nettype wire

// ===== tb/ecp_periph.sv
/* cable peripheral model: busy follows strobe, reverse bytes count
   up from 8'h30. assumes the engine's registered pin outputs */
`timescale 1ns/10ps
`default_nettype none
module ecp_periph
   import ecp_pkg::*;
(
   // bench control
   input  wire logic       clk,
   input  wire logic       reverse,
   input  wire logic [4:0] dly,
   input  wire logic       req,
   // cable
   input  wire ecp_pins_t  pins,
   output logic            busy,
   output logic            ack_n,
   output logic            fault_n,
   output logic [7:0]      pd_in
);
   logic [4:0] bcnt, acnt;
   logic [7:0] byte_q;
   logic       busy_t, ack_t;
   assign busy_t = !reverse && !pins.strobe_n;
   assign ack_t = !reverse || pins.alf_n;
   assign fault_n = !req;
   // released bus shows the inverse so stale data never matches
   assign pd_in = (reverse && (!ack_n || !pins.alf_n)) ? byte_q : ~byte_q;
   initial begin
      busy = 1'b0;
      ack_n = 1'b1;
      bcnt = 5'h0;
      acnt = 5'h0;
      byte_q = 8'h30;
   end
   always @(posedge clk) begin
      bcnt <= (busy == busy_t) ? 5'h0 : bcnt + 5'h1;
      acnt <= (ack_n == ack_t) ? 5'h0 : acnt + 5'h1;
      if (busy != busy_t && bcnt >= dly)
         busy <= busy_t;
      if (ack_n != ack_t && acnt >= dly) begin
         ack_n <= ack_t;
         if (ack_t)
            byte_q <= byte_q + 8'h1;
      end
   end
endmodule
`default_nettype wire

// ===== tb/ecp_handshake_tb_top.sv
/* bench: compat, fifo and ecp forward runs, ecp reverse with stalls.
   assumes ecp_periph on the cable side and a 50 MHz clock */
`timescale 1ns/10ps
`default_nettype none
module ecp_handshake_tb_top
   import ecp_pkg::*;
   ;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   ecp_mode_t  mode = MODE_COMPAT;
   logic       reverse = 1'b0;
   logic       tx_valid = 1'b0;
   logic       rx_ready = 1'b0;
   logic       tc = 1'b0;
   logic       req = 1'b0;
   ecp_word_t  tx_word = '0;
   logic [4:0] dly = 5'h3;
   logic       tx_ready, rx_valid, periph_req, busy, ack_n, fault_n;
   logic [7:0] rx_data, pd_in;
   ecp_pins_t  pins;
   ecp_oe_t    pins_oe;
   int         failures = 0;
   int         checked = 0;
   always #10 clk = ~clk;
   ecp_handshake uut (.clk, .reset, .mode, .reverse, .tx_word, .tx_valid,
      .tx_ready, .rx_data, .rx_valid, .rx_ready, .tc, .busy, .ack_n, .fault_n,
      .pd_in, .pins, .pins_oe, .periph_req);
   ecp_periph per (.clk, .reverse, .dly, .req, .pins, .busy, .ack_n, .fault_n, .pd_in);
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic push(input logic cmd, input logic [7:0] d);
      @(negedge clk);
      tx_word = '{cmd, d};
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1)
         @(negedge clk);
      @(posedge clk);
   endtask
   task automatic grab(output ecp_pins_t p);
      int n = 0;
      while (pins.strobe_n !== 1'b1 && n++ < 3000)
         @(negedge clk);
      while (pins.strobe_n !== 1'b0 && n++ < 3000)
         @(negedge clk);
      p = pins;
   endtask
   task automatic take(input logic [7:0] exp, input int hold);
      int n = 0;
      while (rx_valid !== 1'b1 && n++ < 3000)
         @(negedge clk);
      repeat (hold) @(negedge clk);
      chk("rx", {exp, 2'b10}, {rx_data, rx_valid, pins.alf_n});
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
   endtask
   // three words: the buffer stays full while the first byte is on the cable
   task automatic t_fwd(input ecp_mode_t m, input logic [4:0] d);
      ecp_pins_t p;
      logic [9:0] e;
      repeat (60) @(negedge clk);
      mode = m;
      dly = d;
      req = (m == MODE_ECP);
      fork
         begin
            for (int i = 0; i < 3; i++)
               push(i[0], 8'ha0 + 8'(i));
            @(negedge clk);
            tx_valid = 1'b0;
         end
         for (int i = 0; i < 3; i++) begin
            grab(p);
            e = {8'ha0 + 8'(i), 1'b0, (m == MODE_ECP) ? !i[0] : 1'b1};
            chk("pins", e, p);
            chk("oe", (m == MODE_ECP) ? 10'h0 : e, pins_oe);
         end
      join
      chk("req", {9'h0, req}, {9'h0, periph_req});
      $display("done forward mode %0d", m);
   endtask
   task automatic t_rev;
      // the last forward byte must finish before the channel turns
      repeat (60) @(negedge clk);
      reverse = 1'b1;
      dly = 5'h8;
      tc = 1'b1;
      repeat (100) @(negedge clk);
      chk("tc stall", 10'h0, {8'h0, rx_valid, pins.alf_n});
      chk("oe", 10'h3fc, pins_oe);
      tc = 1'b0;
      take(8'h30, 100);
      take(8'h31, 0);
      take(8'h32, 0);
      $display("done reverse");
   endtask
   task automatic t_reset;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      chk("pins", 10'h3ff, pins);
      chk("oe", 10'h3ff, pins_oe);
      chk("flags", 10'h1, {7'h0, rx_valid, periph_req, tx_ready});
      $display("done reset");
   endtask
   initial begin
      t_reset();
      t_fwd(MODE_COMPAT, 5'h3);
      t_fwd(MODE_FIFO, 5'h14);
      t_fwd(MODE_ECP, 5'hc);
      t_rev();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire
